// >>> cpmc_pkg.sv
// Purpose: Constants for the clock and power mode controller
// Assumes: Register port with 4-bit word address and 8-bit data
// Notes:   Offsets, field positions, reset values and timing counts
package cpmc_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 4;
  // Register offsets
  localparam logic [3:0] OFF_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFF_IRQ_FLAG = 4'h1;
  localparam logic [3:0] OFF_IRQ_EN   = 4'h2;
  localparam logic [3:0] OFF_PIN_CFG  = 4'h3;
  localparam logic [3:0] OFF_STATUS   = 4'h4;
  // Oscillator control fields
  localparam int unsigned OSC_SEL_BIT   = 0;
  localparam int unsigned OSC_STOP_BIT  = 1;
  localparam int unsigned OSC_MODE_LO   = 2;
  localparam int unsigned OSC_SLOWT0_BIT = 4;
  localparam int unsigned OSC_TIMER0_ENABLE_BIT  = 5;
  localparam int unsigned OSC_TIMER1_ENABLE_BIT  = 6;
  localparam logic [7:0]  OSC_RESET     = 8'h01;
  localparam logic [7:0]  OSC_WMASK     = 8'h7F;
  // Power mode field codes
  localparam logic [1:0] MODE_RUN     = 2'b00;
  localparam logic [1:0] MODE_HALT    = 2'b01;
  localparam logic [1:0] MODE_STANDBY = 2'b10;
  // Interrupt flag and enable fields
  localparam int unsigned IRQ_PIN_BIT  = 0;
  localparam int unsigned IRQ_LOW_BIT  = 1;
  localparam int unsigned IRQ_NV_BIT   = 2;
  localparam int unsigned IRQ_GIE_BIT  = 7;
  localparam int unsigned IRQ_SRC_N    = 3;
  // Pin interrupt configuration fields
  localparam int unsigned PIN_SEL_BIT  = 0;
  localparam int unsigned PIN_EDGE_BIT = 1;
  // Status fields and reset value
  localparam int unsigned ST_PD_BIT    = 3;
  localparam int unsigned ST_TO_BIT    = 4;
  localparam logic [7:0]  STATUS_RESET = 8'h18;
  // Halt wake-up stable time in system clock periods
  localparam int unsigned WAKE_PERIODS = 16;
  localparam logic [4:0]  WAKE_LAST    = 5'(WAKE_PERIODS - 1);
  // Instruction clock dividers
  localparam logic [1:0]  DIV2_LAST    = 2'h1;
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
  // Interrupt vector after wake-up
  localparam logic [7:0]  IRQ_VECTOR   = 8'h08;
  // Fast RC trim codes: 1, 2, 4, 8, 16, 20 MHz; 6 and 7 unused
  localparam logic [2:0]  TRIM_LAST    = 3'h5;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_STBY = 2'b01,
    ST_HALT = 2'b11,
    ST_WAKE = 2'b10
  } cpmc_state_e;
endpackage

// >>> cpmc_top.sv
// Purpose: Clock source select, operating modes, wake-up and three irq flags
// Assumes: mclk_in stands for the system clock; inputs synchronous to it
// Notes:   Notes on behaviour list below; registers on a plain strobe port
// Notes on behaviour
// [RULE_01] Selected pin edge sets pin flag
// [RULE_02] Falling detector output sets low-supply flag
// [RULE_03] Finished nonvolatile write sets done flag
// [RULE_04] Select bit picks fast or slow clock
// [RULE_05] Instruction clock is system clock over 2/4
// [RULE_06] Fast oscillator frequency set by three-bit code
// [RULE_07] Stop bit stops the fast oscillator
// [RULE_08] Startup strap picks normal or slow mode
// [RULE_09] Mode field 10 standby, 01 halt
// [RULE_10] Sleep instruction also enters halt
// [RULE_11] Halt entry: clear power-down, set time-out, clear watchdog
// [RULE_12] Standby stops execution, keeps oscillators and timers
// [RULE_13] Standby wakes on six event kinds
// [RULE_14] Halt disables both oscillators and peripherals
// [RULE_15] Halt wakes on watchdog, port change, pin
// [RULE_16] After wake, select bit picks resulting mode
// [RULE_17] Halt wake waits 16 clocks; standby none
// [RULE_18] Wake with global enable branches to vector
// [RULE_19] Firmware: go slow before stopping fast oscillator
// [RULE_20] Firmware: no select change with standby entry
// [RULE_21] Stop bit change with halt entry accepted
// [RULE_22] Normal mode: slow clock may drive timer0
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpmc_top
  import cpmc_pkg::*;
#(
  parameter int unsigned WAKE_N = WAKE_PERIODS
) (
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              cfg_fast_startup_in,
  input  wire logic              cfg_inst_div4_in,
  input  wire logic [2:0]        cfg_fast_trim_in,
  input  wire logic              cfg_timer0_src_in,
  input  wire logic              port_b_pin0_in,
  input  wire logic              low_supply_detector_in,
  input  wire logic              nv_write_done_in,
  input  wire logic              timer0_ovf_in,
  input  wire logic              timer1_unf_in,
  input  wire logic              wdt_timeout_in,
  input  wire logic              port_b_change_in,
  input  wire logic              sleep_exec_in,
  input  wire logic              irq_on_instruction_in,
  input  wire logic              irq_off_instruction_in,
  output logic                   fast_osc_en_out,
  output logic                   slow_osc_en_out,
  output logic [2:0]             fast_osc_trim_out,
  output logic                   sys_clk_fast_out,
  output logic                   inst_tick_out,
  output logic                   exec_run_out,
  output logic                   periph_en_out,
  output logic                   timer0_run_out,
  output logic                   timer1_run_out,
  output logic                   timer0_slow_clk_out,
  output logic                   wdt_clear_out,
  output logic                   irq_req_out,
  output logic                   irq_vector_out,
  output logic [DATA_W-1:0]      vector_addr_out,
  output logic [1:0]             power_mode_out
);

  cpmc_state_e         state_q;
  logic [DATA_W-1:0]   osc_q;
  logic [IRQ_SRC_N-1:0] flag_q;
  logic [IRQ_SRC_N-1:0] en_q;
  logic                gie_q;
  logic [1:0]          pin_cfg_q;
  logic                pd_q;
  logic                to_q;
  logic                strap_done_q;
  logic                pin_prev_q;
  logic                low_prev_q;
  logic                gie_entry_q;
  logic [4:0]          wake_cnt_q;
  logic [1:0]          div_q;
  logic                vector_q;
  logic                wdt_clr_q;
  logic [DATA_W-1:0]   rdata_q;
  logic [2:0]          trim_q;

  logic wr_osc;
  logic pin_evt;
  logic low_evt;
  logic halt_req;
  logic stby_req;
  logic stby_wake;
  logic halt_wake;
  logic [IRQ_SRC_N-1:0] set_vec;
  logic [4:0]          wake_last;

  assign wake_last = 5'(WAKE_N - 1);

  // Register write decode shared by the mode logic
  assign wr_osc = wr_in && (addr_in == OFF_OSC_CTRL);

  // Edge detection on the pin and the detector output
  assign pin_evt = pin_cfg_q[PIN_SEL_BIT] &&
                   (pin_cfg_q[PIN_EDGE_BIT] ? (port_b_pin0_in && !pin_prev_q)
                                            : (!port_b_pin0_in && pin_prev_q)); // RULE_01
  assign low_evt = low_prev_q && !low_supply_detector_in; // RULE_02

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_prev_q <= 1'b0;
      low_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= port_b_pin0_in;
      low_prev_q <= low_supply_detector_in;
    end
  end

  // Mode requests; only honoured while executing
  assign halt_req = (state_q == ST_RUN) &&
                    (sleep_exec_in || (wr_osc &&
                     wdata_in[OSC_MODE_LO+1:OSC_MODE_LO] == MODE_HALT)); // RULE_09 RULE_10
  assign stby_req = (state_q == ST_RUN) && !halt_req && wr_osc &&
                    (wdata_in[OSC_MODE_LO+1:OSC_MODE_LO] == MODE_STANDBY); // RULE_09

  // Wake sources differ per mode; halt has no timers or detector running
  assign stby_wake = timer0_ovf_in || timer1_unf_in || wdt_timeout_in ||
                     port_b_change_in || pin_evt || low_evt; // RULE_13
  assign halt_wake = wdt_timeout_in || port_b_change_in || pin_evt; // RULE_15

  // Operating mode sequencer
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q    <= ST_RUN;
      wake_cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          wake_cnt_q <= 5'h00;
          if (halt_req) begin
            state_q <= ST_HALT;
          end else if (stby_req) begin
            state_q <= ST_STBY;
          end
        end
        ST_STBY: begin
          if (stby_wake) begin
            state_q <= ST_RUN; // RULE_17
          end
        end
        ST_HALT: begin
          if (halt_wake) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_cnt_q == wake_last) begin
            state_q <= ST_RUN; // RULE_17
          end else begin
            wake_cnt_q <= wake_cnt_q + 5'h01;
          end
        end
      endcase
    end
  end

  // Oscillator control register; strap loads the select bit once after reset
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_q        <= OSC_RESET;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        osc_q[OSC_SEL_BIT] <= cfg_fast_startup_in; // RULE_08
      end else if (wr_osc && state_q == ST_RUN) begin
        // Stop bit and halt code land together in one write
        osc_q <= wdata_in & OSC_WMASK; // RULE_21
      end else if (state_q == ST_WAKE || (state_q == ST_STBY && stby_wake)) begin
        // Field returns to run; select bit kept, so it decides the mode
        osc_q[OSC_MODE_LO+1:OSC_MODE_LO] <= MODE_RUN; // RULE_16
      end
    end
  end

  // Sticky flags; a set in the same cycle as a write of zero wins
  assign set_vec = {nv_write_done_in, low_evt, pin_evt}; // RULE_03
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_q <= '0;
    end else if (wr_in && addr_in == OFF_IRQ_FLAG) begin
      flag_q <= (flag_q & wdata_in[IRQ_SRC_N-1:0]) | set_vec; // RULE_01 RULE_02 RULE_03
    end else begin
      flag_q <= flag_q | set_vec; // RULE_01 RULE_02 RULE_03
    end
  end

  // Enables and global enable; instructions override a register write
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      en_q      <= '0;
      gie_q     <= 1'b0;
      pin_cfg_q <= 2'b00;
    end else begin
      if (wr_in && addr_in == OFF_IRQ_EN) begin
        en_q  <= wdata_in[IRQ_SRC_N-1:0];
        gie_q <= wdata_in[IRQ_GIE_BIT];
      end
      if (irq_on_instruction_in) begin
        gie_q <= 1'b1;
      end else if (irq_off_instruction_in) begin
        gie_q <= 1'b0;
      end
      if (wr_in && addr_in == OFF_PIN_CFG) begin
        pin_cfg_q <= wdata_in[1:0];
      end
    end
  end

  // Request only with both the source enable and global enable
  assign irq_req_out = gie_q && |(flag_q & en_q); // RULE_01 RULE_02 RULE_03

  // Status bits: halt entry and watchdog time-out
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pd_q      <= STATUS_RESET[ST_PD_BIT];
      to_q      <= STATUS_RESET[ST_TO_BIT];
      wdt_clr_q <= 1'b0;
    end else begin
      wdt_clr_q <= halt_req; // RULE_11
      if (halt_req) begin
        pd_q <= 1'b0; // RULE_11
        to_q <= 1'b1; // RULE_11
      end else if (wdt_timeout_in) begin
        to_q <= 1'b0;
      end
    end
  end
  assign wdt_clear_out = wdt_clr_q;

  // Remember global enable at entry; branch pulse on return to run
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      gie_entry_q <= 1'b0;
      vector_q    <= 1'b0;
    end else begin
      if (halt_req || stby_req) begin
        gie_entry_q <= gie_q;
      end
      vector_q <= gie_entry_q && ((state_q == ST_STBY && stby_wake) ||
                  (state_q == ST_WAKE && wake_cnt_q == wake_last)); // RULE_18
    end
  end
  assign irq_vector_out  = vector_q;
  assign vector_addr_out = IRQ_VECTOR;

  // Instruction clock divider; cleared to zero while execution stops
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 2'h0;
    end else if (state_q != ST_RUN || inst_tick_out) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign inst_tick_out = (state_q == ST_RUN) &&
                         (div_q == (cfg_inst_div4_in ? DIV4_LAST : DIV2_LAST)); // RULE_05

  // Trim code registered; unused codes fall back to the top frequency
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      trim_q <= 3'h0;
    end else begin
      trim_q <= (cfg_fast_trim_in > TRIM_LAST) ? TRIM_LAST : cfg_fast_trim_in; // RULE_06
    end
  end
  assign fast_osc_trim_out = trim_q;

  // Oscillator and peripheral gating per mode
  assign fast_osc_en_out = (state_q != ST_HALT) && !osc_q[OSC_STOP_BIT]; // RULE_07 RULE_14
  assign slow_osc_en_out = (state_q != ST_HALT); // RULE_12 RULE_14
  assign sys_clk_fast_out = osc_q[OSC_SEL_BIT]; // RULE_04
  assign exec_run_out    = (state_q == ST_RUN); // RULE_12
  assign periph_en_out   = (state_q == ST_RUN); // RULE_14
  assign timer0_run_out  = osc_q[OSC_TIMER0_ENABLE_BIT] &&
                           (state_q == ST_RUN || state_q == ST_STBY); // RULE_12
  assign timer1_run_out  = osc_q[OSC_TIMER1_ENABLE_BIT] &&
                           (state_q == ST_RUN || state_q == ST_STBY); // RULE_12
  // Slow clock to timer0 only in normal mode with both controls set
  assign timer0_slow_clk_out = (state_q == ST_RUN) && osc_q[OSC_SEL_BIT] &&
                               osc_q[OSC_SLOWT0_BIT] && cfg_timer0_src_in; // RULE_22
  assign power_mode_out = osc_q[OSC_MODE_LO+1:OSC_MODE_LO];

  // Read port; unmapped offsets read zero
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        OFF_OSC_CTRL: rdata_q <= osc_q;
        OFF_IRQ_FLAG: rdata_q <= {5'h00, flag_q};
        OFF_IRQ_EN:   rdata_q <= {gie_q, 4'h0, en_q};
        OFF_PIN_CFG:  rdata_q <= {6'h00, pin_cfg_q};
        OFF_STATUS:   rdata_q <= {3'h0, to_q, pd_q, 3'h0};
        default:      rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_out = rdata_q;

  // Checks
  a_pin_flag_set: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_01
    pin_evt |=> flag_q[IRQ_PIN_BIT]) else $error("pin flag not set");
  a_low_flag_set: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_02
    $fell(low_supply_detector_in) |=> flag_q[IRQ_LOW_BIT])
    else $error("low supply flag not set");
  a_nv_flag_set: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_03
    nv_write_done_in |=> flag_q[IRQ_NV_BIT] [*2]) else $error("nv flag lost");
  a_halt_osc_off: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_14
    halt_req |=> !fast_osc_en_out && !slow_osc_en_out && !periph_en_out)
    else $error("oscillators running in halt");
  a_halt_status: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_11
    halt_req |=> !pd_q && to_q && wdt_clear_out) else $error("halt status wrong");
  a_stby_entry: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_12
    stby_req |=> state_q == ST_STBY && slow_osc_en_out && !exec_run_out)
    else $error("standby entry wrong");
  // Sixteen wake cycles with execution off, then run; written for the default count
  a_wake_delay: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_17
    (state_q == ST_HALT && halt_wake) |=>
      !exec_run_out [*8] ##1 !exec_run_out [*8] ##1 exec_run_out)
    else $error("halt wake delay wrong");
  a_stby_wake: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_13
    (state_q == ST_STBY && timer0_ovf_in) |=> exec_run_out)
    else $error("standby did not wake");
  a_halt_ignore: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_15
    (state_q == ST_HALT && !halt_wake) |=> state_q == ST_HALT)
    else $error("halt left without source");
  a_vector_gie: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_18
    (state_q == ST_STBY && stby_wake && gie_entry_q) |=> irq_vector_out)
    else $error("no vector after wake");
  a_div_tick: assert property (@(posedge mclk_in) disable iff (reset_in) // RULE_05
    (inst_tick_out && !cfg_inst_div4_in && state_q == ST_RUN) |=> !inst_tick_out)
    else $error("divider tick spacing wrong");

  c_halt_wake: cover property (@(posedge mclk_in) disable iff (reset_in)
    state_q == ST_WAKE ##1 state_q == ST_RUN);
  c_stby_wake: cover property (@(posedge mclk_in) disable iff (reset_in)
    state_q == ST_STBY ##1 state_q == ST_RUN);
  c_irq_req: cover property (@(posedge mclk_in) disable iff (reset_in) irq_req_out);
  c_slow_t0: cover property (@(posedge mclk_in) disable iff (reset_in)
    timer0_slow_clk_out);

endmodule
`default_nettype wire

// >>> cpmc_top_bench.sv
// Purpose: Self-checking bench for the clock and power mode controller
// Assumes: Strobe register port, one clock, async active-high reset
// Notes:   Expected values come from a small model of flags and wake events
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpmc_top_bench;
  import cpmc_pkg::*;
  logic       mclk_in, reset_in, wr, rd, strap, div4, t0src, pin, low_supply_detector;
  logic       fen, sen, sfast, tick, run, pen, t0r, t1r, t0slow, wclr, ireq, ivec;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, ev, vaddr;
  logic [2:0] trim, trim_o;
  logic [1:0] pmode;
  int         bad_count, checks_done, cyc, n, k, idx, exp_flags;
  int         wake_q[$];

  // Pulse inputs: 0 nv done, 1 t0 ovf, 2 t1 unf, 3 wdt, 4 pb change, 5 sleep, 6 on, 7 off
  cpmc_top #(.WAKE_N(WAKE_PERIODS)) cpmc_top_i (
    .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cfg_fast_startup_in(strap),
    .cfg_inst_div4_in(div4), .cfg_fast_trim_in(trim), .cfg_timer0_src_in(t0src),
    .port_b_pin0_in(pin), .low_supply_detector_in(low_supply_detector), .nv_write_done_in(ev[0]),
    .timer0_ovf_in(ev[1]), .timer1_unf_in(ev[2]), .wdt_timeout_in(ev[3]),
    .port_b_change_in(ev[4]), .sleep_exec_in(ev[5]), .irq_on_instruction_in(ev[6]),
    .irq_off_instruction_in(ev[7]), .fast_osc_en_out(fen), .slow_osc_en_out(sen),
    .fast_osc_trim_out(trim_o), .sys_clk_fast_out(sfast), .inst_tick_out(tick),
    .exec_run_out(run), .periph_en_out(pen), .timer0_run_out(t0r),
    .timer1_run_out(t1r), .timer0_slow_clk_out(t0slow), .wdt_clear_out(wclr),
    .irq_req_out(ireq), .irq_vector_out(ivec), .vector_addr_out(vaddr),
    .power_mode_out(pmode)
  );

  // Clock, 25 ns period
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Land just after the next edge so registered outputs have settled
  task automatic step();
    @(posedge mclk_in);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // One-cycle event pulse; returns in the cycle after it was taken
  task automatic pulse(input int b);
    @(posedge mclk_in);
    ev[b] <= 1'b1;
    @(posedge mclk_in);
    ev[b] <= 1'b0;
    #1;
  endtask

  // Reset held five cycles; strap sampled at the first edge after release
  task automatic do_reset(input logic s);
    @(posedge mclk_in);
    strap    <= s;
    reset_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  initial begin
    {reset_in, wr, rd, addr, wdata, ev} = '0;
    {strap, div4, t0src, pin, low_supply_detector, trim} = {5'b10001, 3'h0};
    {bad_count, checks_done, cyc, exp_flags} = '0;
    n = $urandom(32'h016B);
    do_reset(1'b1);
    // Reset values, read-only status and an unmapped place
    `CHK({sfast, run}, 2'b11)
    chk_reg(OFF_OSC_CTRL, OSC_RESET);
    wr_reg(OFF_STATUS, 8'h00);
    chk_reg(OFF_STATUS, STATUS_RESET);
    wr_reg(4'hF, 8'hFF);
    chk_reg(4'hF, 8'h00);
    // Instruction tick rate; div2 first so the divider never overshoots
    for (k = 0; k < 2; k++) begin
      @(posedge mclk_in);
      div4 <= k[0];
      n = 0;
      repeat (16) begin
        step();
        n += int'(tick);
      end
      `CHK(n, (k == 1) ? 4 : 8)
    end
    // Random trim codes, codes above 5 clamp
    repeat (6) begin
      @(posedge mclk_in);
      trim <= 3'($urandom % 8);
      step();
      step();
      `CHK(trim_o, (trim > TRIM_LAST) ? TRIM_LAST : trim)
    end
    // Go slow first, then stop the fast oscillator in a separate write
    wr_reg(OFF_OSC_CTRL, 8'h00);
    `CHK(sfast, 1'b0)
    wr_reg(OFF_OSC_CTRL, 8'h02);
    `CHK({fen, sen}, 2'b01)
    wr_reg(OFF_OSC_CTRL, 8'h01);
    `CHK({sfast, fen}, 2'b11)
    // Slow clock to timer0 needs select, routing bit and source config
    wr_reg(OFF_OSC_CTRL, 8'h71);
    for (k = 0; k < 2; k++) begin
      @(posedge mclk_in);
      t0src <= k[0];
      #1;
      `CHK({t0slow, t0r, t1r}, {k[0], 2'b11})
    end
    // Three flag sources, gated by enables and global enable
    wr_reg(OFF_PIN_CFG, 8'h03);
    wr_reg(OFF_IRQ_EN, 8'h87);
    @(posedge mclk_in);
    pin <= 1'b1;
    low_supply_detector <= 1'b0;
    step();
    pulse(0);
    exp_flags = 7;
    chk_reg(OFF_IRQ_FLAG, 8'(exp_flags));
    `CHK(ireq, 1'b1)
    pulse(7);
    `CHK(ireq, 1'b0)
    wr_reg(OFF_IRQ_FLAG, 8'h00);
    exp_flags = 0;
    // Wrong-polarity edges must not set anything
    @(posedge mclk_in);
    pin <= 1'b0;
    low_supply_detector <= 1'b1;
    step();
    chk_reg(OFF_IRQ_FLAG, 8'(exp_flags));
    // Standby and every wake source, in random order; 8 pin rise, 9 supply fall
    wake_q = '{1, 2, 3, 4, 8, 9};
    while (wake_q.size() > 0) begin
      idx = $urandom % wake_q.size();
      n = wake_q[idx];
      wake_q.delete(idx);
      k = $urandom % 2;
      wr_reg(OFF_OSC_CTRL, {7'h00, k[0]});
      wr_reg(OFF_OSC_CTRL, {7'h14, k[0]});
      `CHK({run, sen, fen, t0r, pmode}, {4'b0111, MODE_STANDBY})
      if (n < 8) pulse(n);
      else begin
        @(posedge mclk_in);
        if (n == 8) pin <= 1'b1;
        else low_supply_detector <= 1'b0;
        step();
      end
      `CHK({run, pmode, sfast}, {1'b1, MODE_RUN, k[0]})
      @(posedge mclk_in);
      pin <= 1'b0;
      low_supply_detector <= 1'b1;
    end
    // Halt by sleep with global enable on, timers must not wake it
    wr_reg(OFF_OSC_CTRL, 8'h21);
    pulse(6);
    pulse(5);
    `CHK({run, pen, fen, sen, t0r, wclr}, 6'b000001)
    chk_reg(OFF_STATUS, 8'h10);
    pulse(1);
    pulse(2);
    `CHK(run, 1'b0)
    pulse(3);
    for (k = 0; k < WAKE_PERIODS; k++) begin
      `CHK({run, sen}, 2'b01)
      step();
    end
    `CHK({run, ivec, vaddr, sfast}, {2'b11, IRQ_VECTOR, 1'b1})
    // Halt by mode write with the stop bit in the same write, enable off
    pulse(7);
    wr_reg(OFF_OSC_CTRL, 8'h07);
    `CHK({run, fen, sen, pmode}, {3'b000, MODE_HALT})
    pulse(4);
    repeat (WAKE_PERIODS) step();
    `CHK({run, ivec, fen}, 3'b100)
    chk_reg(OFF_OSC_CTRL, 8'h03);
    // Second reset with the slow startup strap
    do_reset(1'b0);
    `CHK({sfast, run}, 2'b01)
    end_of_test();
  end
endmodule
`default_nettype wire
